/* File: hdl/pad_gating_defines.svh */
`ifndef PAD_GATING_DEFINES_SVH
`define PAD_GATING_DEFINES_SVH

// two-wire slave identifiers picked by the strap
`define SLAVE_ID_STRAP_LOW   8'h90
`define SLAVE_ID_STRAP_HIGH  8'hBA

// parked level of gated parallel pins, chosen low to save power
`define PARK_LEVEL           1'b0

// reset values of the enables
`define PAR_EN_RESET         1'b0
`define VIDEO_PWRDN_RESET    1'b0

// width of the pixel data and of the gpio group
`define DATA_BITS            8
`define GPIO_BITS            11

`endif

/* File: hdl/pad_gating_pkg.sv */
`default_nettype none

package pad_gating_pkg;

  // video converter output form
  typedef enum logic [1:0] {
    VIDEO_SINGLE = 2'b01,
    VIDEO_DIFF   = 2'b10
  } video_mode_t;

endpackage

`default_nettype wire

/* File: hdl/pad_output_gating.sv */
`include "pad_gating_defines.svh"
`default_nettype none

module pad_output_gating (
  input  wire logic        clk,                // 25 MHz device clock
  input  wire logic        reset_n,            // async active-low reset
  input  wire logic        address_strap_pin,  // slave id strap pin
  output logic [7:0]       slave_id,           // selected slave identifier
  input  wire logic        mem_sclk_core,      // memory clock from boot
  input  wire logic        mem_sdo_core,       // memory data from boot
  input  wire logic        mem_cs_n_core,      // memory select from boot
  input  wire logic        serial_mem_data_in, // memory data pin
  output logic             mem_data_in_sync,   // synchronised memory data
  output logic             mem_sclk_o,         // memory clock pad out
  output logic             mem_sclk_oe,        // memory clock enable
  output logic             serial_mem_data_out,// memory data pad out
  output logic             mem_sdo_oe,         // memory data enable
  output logic             mem_cs_n_o,         // memory select pad out
  output logic             mem_cs_n_oe,        // memory select enable
  input  wire logic        par_enable,         // parallel port enable
  input  wire logic        bypass_mode,        // sensor core bypass mode
  input  wire logic [10:0] gpio_sel,           // per pin gpio select
  input  wire logic [10:0] gpio_out,           // gpio output values
  input  wire logic [10:0] gpio_dir,           // gpio drive when high
  input  wire logic        frame_valid_core,   // frame valid from pipe
  input  wire logic        row_valid_core,     // row valid from pipe
  input  wire logic        pixel_strobe_core,  // pixel strobe from pipe
  input  wire logic [9:0]  pixel_core,         // ten-bit pixel from pipe
  input  wire logic [10:0] par_pin_i,          // parallel pad inputs
  output logic [10:0]      par_pin_o,          // {fv,rv,strobe,data[7:0]}
  output logic [10:0]      par_pin_oe,         // parallel pad enables
  output logic [10:0]      gpio_in,            // synchronised pad inputs
  input  wire logic [1:0]  extra_sel,          // extra pin gpio select
  input  wire logic [1:0]  extra_out,          // extra pin gpio values
  input  wire logic [1:0]  extra_dir,          // extra pin gpio drive
  input  wire logic [1:0]  extra_pin_i,        // extra pad inputs
  output logic             extra_bit_high,     // extra pin 1 pad out
  output logic             extra_bit_low,      // extra pin 0 pad out
  output logic [1:0]       extra_oe,           // extra pad enables
  output logic [1:0]       extra_in,           // synchronised extra inputs
  input  wire logic        video_power_down,   // software converter off
  input  wire logic        video_diff,         // differential when high
  output logic             video_enable,       // converter running
  output logic             video_out_plus_en,  // plus output active
  output logic             video_out_minus_en, // minus output active
  output pad_gating_pkg::video_mode_t video_mode // output form
);

  // ****************************************************
  // reset release synchroniser
  // ****************************************************
  logic rst_meta_q;
  logic rst_sync_q;

  // assertion is immediate, release waits two edges so no enable
  // leaves its reset value on a metastable release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************
  // pin input synchronisers
  // ****************************************************
  logic        strap_meta_q, strap_q;
  logic        sdi_meta_q, sdi_q;
  logic [12:0] pin_meta_q, pin_q;

  // pads come from outside the clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_q <= 1'b0;
      strap_q      <= 1'b0;
      sdi_meta_q   <= 1'b1;                    // pull-up idle level
      sdi_q        <= 1'b1;
      pin_meta_q   <= 13'h0000;
      pin_q        <= 13'h0000;
    end else begin
      strap_meta_q <= address_strap_pin;
      strap_q      <= strap_meta_q;
      sdi_meta_q   <= serial_mem_data_in;
      sdi_q        <= sdi_meta_q;
      pin_meta_q   <= {extra_pin_i, par_pin_i};
      pin_q        <= pin_meta_q;
    end
  end

  assign mem_data_in_sync = sdi_q;
  assign gpio_in          = pin_q[10:0];
  assign extra_in         = pin_q[12:11];

  // ****************************************************
  // slave identifier strap
  // ****************************************************
  // strap is captured after release and follows the pin while running
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slave_id <= `SLAVE_ID_STRAP_LOW;
    end else if (rst_sync_q) begin
      slave_id <= strap_q ? `SLAVE_ID_STRAP_HIGH
                          : `SLAVE_ID_STRAP_LOW;
    end
  end

  // ****************************************************
  // serial memory pads
  // ****************************************************
  // enables drop straight away on reset, so the pins float
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_sclk_oe         <= 1'b0;
      mem_sdo_oe          <= 1'b0;
      mem_cs_n_oe         <= 1'b0;
      mem_sclk_o          <= 1'b0;
      serial_mem_data_out <= 1'b0;
      mem_cs_n_o          <= 1'b1;
    end else begin
      mem_sclk_oe         <= rst_sync_q;
      mem_sdo_oe          <= rst_sync_q;
      mem_cs_n_oe         <= rst_sync_q;
      mem_sclk_o          <= mem_sclk_core;
      serial_mem_data_out <= mem_sdo_core;
      mem_cs_n_o          <= mem_cs_n_core;
    end
  end

  // ****************************************************
  // parallel port enable
  // ****************************************************
  logic par_en_q;

  // held off until configuration asks for it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      par_en_q <= `PAR_EN_RESET;
    end else begin
      par_en_q <= rst_sync_q & par_enable;
    end
  end

  // ****************************************************
  // parallel pins: pixel, gpio or parked
  // ****************************************************
  logic [10:0] pix_vec;
  assign pix_vec = {frame_valid_core, row_valid_core,
                    pixel_strobe_core, pixel_core[9:2]};

  genvar gi;
  generate
    for (gi = 0; gi < `GPIO_BITS; gi++) begin : g_par
      // gpio takes priority over the pixel function of its pin
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          par_pin_o[gi]  <= `PARK_LEVEL;
          par_pin_oe[gi] <= 1'b0;
        end else if (rst_sync_q && gpio_sel[gi]) begin
          par_pin_o[gi]  <= gpio_out[gi];
          par_pin_oe[gi] <= gpio_dir[gi];
        end else if (par_en_q) begin
          par_pin_o[gi]  <= pix_vec[gi];
          par_pin_oe[gi] <= 1'b1;
        end else begin
          // driven parked rather than floating to save power
          par_pin_o[gi]  <= `PARK_LEVEL;
          par_pin_oe[gi] <= rst_sync_q;
        end
      end
    end
  endgenerate

  // ****************************************************
  // extra low-order pins
  // ****************************************************
  logic [1:0] ext_o_q;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ext_o_q[gi]  <= `PARK_LEVEL;
          extra_oe[gi] <= 1'b0;
        end else if (rst_sync_q && extra_sel[gi]) begin
          ext_o_q[gi]  <= extra_out[gi];
          extra_oe[gi] <= extra_dir[gi];
        end else if (rst_sync_q && bypass_mode) begin
          ext_o_q[gi]  <= pixel_core[gi];
          extra_oe[gi] <= 1'b1;
        end else begin
          ext_o_q[gi]  <= `PARK_LEVEL;
          extra_oe[gi] <= rst_sync_q;
        end
      end
    end
  endgenerate

  assign extra_bit_high = ext_o_q[1];
  assign extra_bit_low  = ext_o_q[0];

  // ****************************************************
  // video converter control
  // ****************************************************
  // converter comes up running; only software stops it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      video_enable       <= ~`VIDEO_PWRDN_RESET;
      video_out_plus_en  <= 1'b1;
      video_out_minus_en <= 1'b0;
      video_mode         <= pad_gating_pkg::VIDEO_SINGLE;
    end else begin
      video_enable       <= ~(rst_sync_q & video_power_down);
      video_out_plus_en  <= ~(rst_sync_q & video_power_down);
      video_out_minus_en <= rst_sync_q & ~video_power_down
                            & video_diff;
      video_mode         <= (rst_sync_q && video_diff)
                            ? pad_gating_pkg::VIDEO_DIFF
                            : pad_gating_pkg::VIDEO_SINGLE;
    end
  end

endmodule

`default_nettype wire

/* File: verif/pad_gating_assertions.sv */
`include "pad_gating_defines.svh"
`default_nettype none
// ***
// pad gating checks
// ***
module pad_gating_assertions (
  input wire logic        clk,                 // device clock
  input wire logic        reset_n,             // async active-low reset
  input wire logic        address_strap_pin,   // slave id strap pin
  input wire logic        par_enable,          // parallel port enable
  input wire logic        bypass_mode,         // core bypass mode
  input wire logic        mem_sclk_core,       // boot memory clock
  input wire logic        mem_sdo_core,        // boot memory data
  input wire logic        mem_cs_n_core,       // boot memory select
  input wire logic        mem_sclk_o,          // memory clock pad
  input wire logic        serial_mem_data_out, // memory data pad
  input wire logic        mem_cs_n_o,          // memory select pad
  input wire logic        mem_sclk_oe,         // memory clock enable
  input wire logic        mem_sdo_oe,          // memory data enable
  input wire logic        mem_cs_n_oe,         // memory select enable
  input wire logic        frame_valid_core,    // frame valid from pipe
  input wire logic        row_valid_core,      // row valid from pipe
  input wire logic        pixel_strobe_core,   // pixel strobe from pipe
  input wire logic        extra_bit_high,      // extra pin 1 pad
  input wire logic        extra_bit_low,       // extra pin 0 pad
  input wire logic        video_diff,          // differential request
  input wire logic        video_power_down,    // converter off request
  input wire logic        video_enable,        // converter running
  input wire logic        video_out_plus_en,   // plus output active
  input wire logic        video_out_minus_en,  // minus output active
  input wire logic [7:0]  slave_id,            // selected identifier
  input wire logic [9:0]  pixel_core,          // ten-bit pixel
  input wire logic [10:0] gpio_sel,            // gpio select
  input wire logic [10:0] gpio_out,            // gpio values
  input wire logic [10:0] gpio_dir,            // gpio drive
  input wire logic [10:0] par_pin_i,           // parallel pad inputs
  input wire logic [10:0] par_pin_o,           // parallel pad outputs
  input wire logic [10:0] par_pin_oe,          // parallel pad enables
  input wire logic [10:0] gpio_in,             // synchronised pad inputs
  input wire logic [1:0]  extra_sel,           // extra pin gpio select
  input wire logic [1:0]  extra_oe             // extra pad enables
);
  timeunit 1ns;
  timeprecision 1ns;
  // edges since release; pixel pins need four, so checks wait for seven
  logic [2:0] age_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence waking_s; age_q < 3'h2; endsequence
  sequence settled_s; age_q == 3'h7; endsequence
  wake_reset_a: assert property (
    waking_s |-> {mem_sclk_oe, mem_sdo_oe, mem_cs_n_oe, par_pin_oe, extra_oe}
    == 16'h0000 && video_enable) else $error("left reset state early");
  strap_id_a: assert property (settled_s |-> slave_id ==
    ($past(address_strap_pin, 3) ? `SLAVE_ID_STRAP_HIGH : `SLAVE_ID_STRAP_LOW))
    else $error("slave id wrong");
  mem_follow_a: assert property (settled_s |-> mem_sdo_oe &&
    mem_cs_n_oe && mem_sclk_oe && mem_cs_n_o == $past(mem_cs_n_core) &&
    {mem_sclk_o, serial_mem_data_out} == {$past(mem_sclk_core),
    $past(mem_sdo_core)}) else $error("memory pads wrong");
  // the enable is registered once before the pins, so it lags two edges
  par_park_a: assert property (settled_s ##0
    !$past(par_enable, 2) && $past(gpio_sel) == 11'h000 |->
    par_pin_o == 11'h000 && par_pin_oe == 11'h7ff)
    else $error("parallel pads not parked");
  par_drive_a: assert property (settled_s ##0
    $past(par_enable, 2) && $past(gpio_sel) == 11'h000 |->
    par_pin_oe == 11'h7ff && par_pin_o == {$past(frame_valid_core),
    $past(row_valid_core), $past(pixel_strobe_core), $past(pixel_core[9:2])})
    else $error("pixel pads wrong");
  gpio_drive_a: assert property (settled_s ##0
    $past(gpio_sel) == 11'h7ff |-> par_pin_oe == $past(gpio_dir) &&
    (par_pin_o & par_pin_oe) == ($past(gpio_out) & par_pin_oe) &&
    gpio_in == $past(par_pin_i, 2)) else $error("gpio pads wrong");
  extra_pix_a: assert property (settled_s ##0
    $past(extra_sel) == 2'h0 |-> extra_oe == 2'h3 &&
    {extra_bit_high, extra_bit_low} == ({2{$past(bypass_mode)}} &
    $past(pixel_core[1:0]))) else $error("extra pads wrong");
  video_ctl_a: assert property (settled_s |->
    {video_enable, video_out_plus_en, video_out_minus_en} ==
    {{2{!$past(video_power_down)}}, $past(video_diff) &&
    !$past(video_power_down)}) else $error("video enables wrong");
endmodule
bind pad_output_gating pad_gating_assertions i_pad_gating_assertions (.*);
`default_nettype wire

/* File: verif/pixel_host.sv */
`default_nettype none
// ***
// host reading the pixel port
// ***
module pixel_host (
  input  wire logic [10:0] pin_o,    // device pad values
  input  wire logic [10:0] pin_oe,   // device pad enables
  input  wire logic [10:0] host_val, // host pad values
  input  wire logic [10:0] host_en,  // host drives when high
  input  wire logic        clk,      // device clock
  output logic      [10:0] pin_i,    // resolved pad level
  output logic      [10:0] seen_q    // level the host captured
);
  timeunit 1ns;
  timeprecision 1ns;
  // a floating pad flips each edge so it never passes for a level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & host_en & host_val)
               | (~pin_oe & ~host_en & ~seen_q);
  initial seen_q = 11'h000;
  always @(posedge clk) seen_q <= pin_i;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
// ***
// pad gating bench
// ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, address_strap_pin = 1'b0, par_enable = 0;
  logic mem_sclk_core = 1'b0, mem_sdo_core = 1'b0, mem_cs_n_core = 1'b1;
  logic bypass_mode = 1'b0;
  logic serial_mem_data_in = 1, frame_valid_core = 0, row_valid_core = 0;
  logic pixel_strobe_core = 0, video_power_down = 0, video_diff = 0;
  logic [9:0] pixel_core = 10'h000;
  logic [10:0] gpio_sel = 0, gpio_out = 0, gpio_dir = 0, host_val = 0;
  logic [10:0] host_en = 0, par_pin_i, par_pin_o, par_pin_oe, gpio_in, seen_q;
  logic [1:0] extra_sel = 0, extra_out = 0, extra_dir = 0;
  logic [1:0] extra_pin_i, extra_oe, extra_in;
  logic [7:0] slave_id;
  logic mem_data_in_sync, mem_sclk_o, mem_sclk_oe, serial_mem_data_out;
  logic mem_sdo_oe, mem_cs_n_o, mem_cs_n_oe, extra_bit_high, extra_bit_low;
  logic video_enable, video_out_plus_en, video_out_minus_en;
  pad_gating_pkg::video_mode_t video_mode;
  int num_errors = 0, check_count = 0;
  `define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
  always #20 clk = ~clk;
  // host pulls extra bit 1 high and bit 0 low when the device lets go
  assign extra_pin_i = (extra_oe & {extra_bit_high, extra_bit_low})
                     | (~extra_oe & 2'b10);
  pad_output_gating i_pad_output_gating (.*);
  pixel_host i_pixel_host (.clk(clk), .pin_o(par_pin_o), .pin_oe(par_pin_oe),
    .host_val(host_val), .host_en(host_en), .pin_i(par_pin_i), .seen_q(seen_q));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task test_done;
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cut a hang short; no scenario comes near this
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
  initial begin
    step(3);
    `CHK("mem oe", 3'h0, {mem_sclk_oe, mem_sdo_oe, mem_cs_n_oe})
    reset_n = 1'b1;
    step(1);
    `CHK("early", 14'h0005, {par_pin_oe, video_enable, video_mode})
    step(6);
    for (int s = 0; s < 2; s++) begin
      address_strap_pin = s[0];
      step(4);
      `CHK("slave id", s[0] ? 8'hba : 8'h90, slave_id)
    end
    {mem_sclk_core, mem_sdo_core, mem_cs_n_core, serial_mem_data_in} = 4'h6;
    step(3);
    `CHK("mem", 7'h3e, {mem_sclk_o, serial_mem_data_out, mem_cs_n_o,
      mem_sclk_oe, mem_sdo_oe, mem_cs_n_oe, mem_data_in_sync})
    `CHK("parked", 22'h3f_f800, {par_pin_oe, par_pin_o})
    {frame_valid_core, row_valid_core, pixel_strobe_core} = 3'h5;
    pixel_core = 10'h2d7;
    par_enable = 1'b1;
    // enable is registered first, pins follow one edge later
    step(2);
    `CHK("pixel", 11'h5b5, par_pin_o)
    `CHK("extra park", 4'hc,
      {extra_oe, extra_bit_high, extra_bit_low})
    bypass_mode = 1'b1;
    step(1);
    `CHK("bypass", 4'hf, {extra_oe, extra_bit_high, extra_bit_low})
    `CHK("host saw", 8'hb5, seen_q[7:0])
    {gpio_sel, gpio_dir, gpio_out} = {11'h7ff, 11'h0f0, 11'h0a5};
    {host_val, host_en} = {11'h555, 11'h70f};
    {extra_sel, extra_dir, extra_out} = 6'h37;
    step(1);
    `CHK("gpio", 22'h07_80a0, {par_pin_oe, par_pin_o & 11'h0f0})
    `CHK("extra gpio", 3'h3, {extra_oe, extra_bit_low})
    step(3);
    `CHK("gpio in", 13'h1697, {gpio_in, extra_in})
    for (int v = 0; v < 4; v++) begin
      {video_power_down, video_diff} = v[1:0];
      step(1);
      `CHK("video", {~v[1], ~v[1], v[0] & ~v[1], v[0], ~v[0]},
        {video_enable, video_out_plus_en, video_out_minus_en,
        video_mode})
    end
    reset_n = 1'b0;
    step(1);
    `CHK("reset", 17'h0_0001, {mem_sclk_oe, mem_sdo_oe, mem_cs_n_oe,
      par_pin_oe, extra_oe, video_enable})
    reset_n = 1'b1;
    step(2);
    test_done;
  end
endmodule
`default_nettype wire
